// >>> srl_bcd_conv.v
// bcd/binary converters for the limit switches and the display
`timescale 1ns/1ps
module srl_bcd_conv (
  bcd_in,
  bin_out,
  bin_in,
  bcd_out
);
  input wire [11:0] bcd_in; // three bcd digits from limit switches
  output reg [7:0] bin_out; // binary limit, saturated at 255
  input wire [8:0] bin_in; // doubled display value
  output reg [11:0] bcd_out; // three bcd digits for display

  reg [9:0] sum; // full weighted sum, up to 999
  reg [20:0] dab; // double dabble work register
  integer i;

  // bcd to binary: weights built from shifts, no multiplier
  always @*
  begin
    sum = ({6'h00, bcd_in[11:8]} << 6) + ({6'h00, bcd_in[11:8]} << 5)
        + ({6'h00, bcd_in[11:8]} << 2) + ({6'h00, bcd_in[7:4]} << 3)
        + ({6'h00, bcd_in[7:4]} << 1) + {6'h00, bcd_in[3:0]};
    // switches above 255 cannot be carried in eight bits; clamp
    bin_out = (sum > 10'h0ff) ? 8'hff : sum[7:0];
  end

  // binary to bcd by shift and add three
  always @*
  begin
    dab = {12'h000, bin_in};
    for (i = 0; i < 9; i = i + 1)
    begin
      if (dab[12:9] > 4'h4)
        dab[12:9] = dab[12:9] + 4'h3;
      if (dab[16:13] > 4'h4)
        dab[16:13] = dab[16:13] + 4'h3;
      if (dab[20:17] > 4'h4)
        dab[20:17] = dab[20:17] + 4'h3;
      dab = {dab[19:0], 1'b0};
    end
    bcd_out = dab[20:9];
  end
endmodule

// >>> srl_far_end.sv
// far-side model: host command register and uplink uart holding buffer
`timescale 1ns/1ps
module srl_far_end (
  input logic clk,
  input logic nrst,
  input logic [31:0] host_word, // actuator 1 in the top byte
  input logic host_load, // parallel load of the host register
  input logic host_shift_clock,
  output logic host_data_in,
  input logic [3:0] tx_busy, // uart busy time: 1 prompt, larger slow
  input logic tx_load,
  output logic tx_holding_empty
);
  logic [31:0] host_reg; // msb is presented first
  logic [3:0] busy; // cycles left before the buffer empties
  // a shift pulse moves the register on its leading edge, so while it stands the next bit is out
  assign host_data_in = host_shift_clock ? host_reg[30] : host_reg[31];
  // host register loads whole, then advances once per shift clock
  // buffer empties a set time after each byte, as a uart would
  always @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      host_reg <= 32'h0000_0000;
      busy <= 4'h0;
      tx_holding_empty <= 1'b1;
    end
    else
    begin
      if (host_load)
        host_reg <= host_word;
      else if (host_shift_clock)
        host_reg <= {host_reg[30:0], ~host_reg[0]}; // spent bits toggle, never stale
      if (tx_load)
      begin
        busy <= tx_busy;
        tx_holding_empty <= 1'b0;
      end
      else if (busy != 4'h0)
        busy <= busy - 4'h1;
      else
        tx_holding_empty <= 1'b1;
    end
endmodule

// >>> srl_link_sequencer.v
// control-room link sequencer: status word, command fetch, uplink framer, downlink decoder
`timescale 1ns/1ps
`include "srl_map.vh"
module srl_link_sequencer #(
  parameter POR_CYCLES = `SRL_POR_MS * `SRL_CLK_KHZ,
  parameter LOAD_DLY_CYCLES = `SRL_LOAD_DLY_MS * `SRL_CLK_KHZ
) (
  clk,
  nrst,
  ce,
  wb_cyc_i,
  wb_stb_i,
  wb_we_i,
  wb_adr_i,
  wb_sel_i,
  wb_dat_i,
  wb_ack_o,
  wb_dat_o,
  host_cmd_loaded,
  host_data_in,
  cmd_shift_clock,
  host_shift_clock,
  cmd_fetch_done,
  status_data,
  status_shift_clock,
  status_word_valid,
  status_seq_restart,
  tx_holding_empty,
  tx_load,
  tx_data,
  rx_valid,
  rx_data,
  temperature_alert_n,
  lock_alert_n
);
  input wire clk;
  input wire nrst;
  input wire ce; // low freezes every flop
  input wire wb_cyc_i;
  input wire wb_stb_i;
  input wire wb_we_i;
  input wire [7:0] wb_adr_i;
  input wire [3:0] wb_sel_i;
  input wire [31:0] wb_dat_i;
  output reg wb_ack_o;
  output reg [31:0] wb_dat_o;
  input wire host_cmd_loaded; // host has loaded actuator 4 word
  input wire host_data_in; // serial bit from host command register
  output reg cmd_shift_clock; // one pulse per bit taken
  output reg host_shift_clock; // advances the host register
  output reg cmd_fetch_done;
  output reg status_data;
  output reg status_shift_clock;
  output reg status_word_valid;
  output reg status_seq_restart;
  input wire tx_holding_empty;
  output reg tx_load;
  output reg [7:0] tx_data;
  input wire rx_valid; // one-cycle strobe per received byte
  input wire [4:0] rx_data; // bits one to five of the byte
  output reg temperature_alert_n;
  output reg lock_alert_n;

  // software-visible settings (front panel stand-ins)
  reg comp_mode; // computer mode when high
  reg update_press; // one-cycle update-enable press
  reg [3:0] update_select; // manual per-actuator update select
  reg [3:0] display_select;
  reg [11:0] limit_bcd;
  reg [31:0] manual_pos; // actuator 1 in low byte

  // sequencer state
  reg comp_mode_d; // previous mode for change detect
  reg mode_change_pulse;
  reg [31:0] por_cnt;
  reg por_done;
  reg loaded_d;
  reg dly_run;
  reg [31:0] dly_cnt;
  reg stat_busy;
  reg [3:0] stat_cnt;
  reg [10:0] stat_shift;
  reg ld_s1, ld_s2, ld_s3; // load stretch chain
  reg fetch_run;
  reg [4:0] fetch_cnt;
  reg [31:0] cmd_reg; // actuator 1 in top byte
  reg cmd_valid;
  reg fmt_run;
  reg load_pend;
  reg [3:0] grp;
  reg [47:0] dn_shift; // twelve downlink nibbles
  reg [31:0] dn_pos;
  reg [7:0] dn_lim;
  reg [7:0] dn_temp;
  reg [3:0] dn_stat;

  wire [7:0] position_limit_bits;
  wire [11:0] display_bcd;
  wire [10:0] status_word;
  wire [31:0] wmask;
  wire wb_hit;
  wire ld_stretch;

  // combinational helpers
  reg [1:0] act;
  reg [1:0] phase;
  reg [7:0] pos;
  reg allow;
  reg [7:0] group_byte;
  reg [7:0] disp_val;
  reg [31:0] rd_val;

  srl_bcd_conv u_conv (
    .bcd_in(limit_bcd),
    .bin_out(position_limit_bits),
    .bin_in({disp_val, 1'b0}),
    .bcd_out(display_bcd)
  );

  // the word the host reads; alerts are active low
  assign status_word = {comp_mode, temperature_alert_n, lock_alert_n, position_limit_bits};

  assign wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // two cycles of stretch so a one-cycle load is never missed
  assign ld_stretch = ld_s2 | ld_s3;

  // wishbone slave: one ack per request, dropped the next cycle
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      comp_mode <= 1'b0;
      update_press <= 1'b0;
      update_select <= 4'h0;
      display_select <= 4'h0;
      limit_bcd <= `SRL_LIMIT_RST;
      manual_pos <= `SRL_MANPOS_RST;
    end
    else if (ce)
    begin
      wb_ack_o <= wb_hit;
      update_press <= 1'b0;
      wb_dat_o <= wb_hit ? rd_val : 32'h0000_0000;
      if (wb_hit && wb_we_i)
      begin
        case (wb_adr_i)
          `SRL_OFS_CTRL:
          begin
            if (wb_sel_i[0])
            begin
              comp_mode <= wb_dat_i[`SRL_CTRL_COMP];
              update_press <= wb_dat_i[`SRL_CTRL_PRESS];
              update_select <= wb_dat_i[`SRL_CTRL_USEL_LO +: 4];
            end
            if (wb_sel_i[1])
              display_select <= wb_dat_i[`SRL_CTRL_DSEL_LO +: 4];
          end
          `SRL_OFS_LIMIT:
            limit_bcd <= (limit_bcd & wmask[11:0]) ^ limit_bcd ^ (wb_dat_i[11:0] & wmask[11:0]);
          `SRL_OFS_MANPOS:
            manual_pos <= (manual_pos & ~wmask) | (wb_dat_i & wmask);
          default:
            // read-only or unmapped: write is acked and dropped
            update_press <= 1'b0;
        endcase
      end
    end
  end

  // read mux; unmapped offsets read zero
  always @*
  begin
    case (wb_adr_i)
      `SRL_OFS_CTRL: rd_val = {20'h00000, display_select, update_select, 3'h0, comp_mode};
      `SRL_OFS_LIMIT: rd_val = {12'h000, position_limit_bits, limit_bcd};
      `SRL_OFS_MANPOS: rd_val = manual_pos;
      `SRL_OFS_STATUS: rd_val = {12'h000, grp, fmt_run, cmd_valid, fetch_run, stat_busy,
                                  status_word_valid, status_word};
      `SRL_OFS_CMD: rd_val = cmd_reg;
      `SRL_OFS_DNPOS: rd_val = dn_pos;
      `SRL_OFS_DNMISC: rd_val = {12'h000, dn_stat, dn_temp, dn_lim};
      `SRL_OFS_DISP: rd_val = {20'h00000, display_bcd};
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // restart sources: power-up hold, mode change, delayed command load
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      por_cnt <= 32'h0000_0000;
      por_done <= 1'b0;
      comp_mode_d <= 1'b0;
      mode_change_pulse <= 1'b0;
      loaded_d <= 1'b0;
      dly_run <= 1'b0;
      dly_cnt <= 32'h0000_0000;
      status_seq_restart <= 1'b0;
    end
    else if (ce)
    begin
      comp_mode_d <= comp_mode;
      mode_change_pulse <= comp_mode ^ comp_mode_d;
      loaded_d <= host_cmd_loaded;
      // power-on hold, stands in for the long low reset line
      if (!por_done)
      begin
        if (por_cnt == POR_CYCLES - 1)
          por_done <= 1'b1;
        else
          por_cnt <= por_cnt + 32'h0000_0001;
      end
      // new load restarts the wait so the lock bit reflects the latest command
      if (host_cmd_loaded && !loaded_d)
      begin
        dly_run <= 1'b1;
        dly_cnt <= 32'h0000_0000;
      end
      else if (dly_run)
      begin
        if (dly_cnt == LOAD_DLY_CYCLES - 1)
          dly_run <= 1'b0;
        else
          dly_cnt <= dly_cnt + 32'h0000_0001;
      end
      status_seq_restart <= (!por_done && por_cnt == POR_CYCLES - 1) | mode_change_pulse
                            | (dly_run && dly_cnt == LOAD_DLY_CYCLES - 1);
    end
  end

  // status serialiser: word shifts out one bit per cycle, msb first, counter ends the run
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      stat_busy <= 1'b0;
      stat_cnt <= 4'h0;
      stat_shift <= 11'h000;
      status_data <= 1'b0;
      status_shift_clock <= 1'b0;
      status_word_valid <= 1'b0;
    end
    else if (ce)
    begin
      if (status_seq_restart)
      begin
        // fixed start state, word captured at this edge
        stat_busy <= 1'b1;
        stat_cnt <= 4'h0;
        stat_shift <= status_word;
        status_shift_clock <= 1'b0;
        status_word_valid <= 1'b0;
      end
      else if (stat_busy)
      begin
        status_data <= stat_shift[10];
        status_shift_clock <= 1'b1;
        stat_shift <= {stat_shift[9:0], 1'b0};
        stat_cnt <= stat_cnt + 4'h1;
        if (stat_cnt == `SRL_STAT_LAST)
          stat_busy <= 1'b0;
      end
      else
      begin
        status_shift_clock <= 1'b0;
        // valid only once a full word has been shifted after power-up
        status_word_valid <= por_done & ~status_shift_clock;
      end
    end
  end

  // command fetch from the host register
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ld_s1 <= 1'b0;
      ld_s2 <= 1'b0;
      ld_s3 <= 1'b0;
      fetch_run <= 1'b0;
      fetch_cnt <= 5'h00;
      cmd_reg <= 32'h0000_0000;
      cmd_shift_clock <= 1'b0;
      host_shift_clock <= 1'b0;
      cmd_fetch_done <= 1'b0;
      cmd_valid <= 1'b0;
    end
    else if (ce)
    begin
      ld_s1 <= host_cmd_loaded & comp_mode;
      ld_s2 <= ld_s1;
      ld_s3 <= ld_s2;
      cmd_fetch_done <= 1'b0;
      cmd_shift_clock <= 1'b0;
      host_shift_clock <= 1'b0;
      if (ld_stretch)
      begin
        // load means all four words are waiting in the host register
        fetch_cnt <= 5'h00;
        fetch_run <= 1'b1;
      end
      else if (fetch_run)
      begin
        // first bit is already present, so the host needs one shift fewer
        cmd_reg <= {cmd_reg[30:0], host_data_in};
        cmd_shift_clock <= 1'b1;
        host_shift_clock <= (fetch_cnt != `SRL_FETCH_LAST);
        fetch_cnt <= fetch_cnt + 5'h01;
        if (fetch_cnt == `SRL_FETCH_LAST)
        begin
          fetch_run <= 1'b0;
          cmd_fetch_done <= 1'b1;
          cmd_valid <= 1'b1;
        end
      end
    end
  end

  // group decode: three bytes per actuator, then three filler groups
  always @*
  begin
    if (grp >= 4'h9)
      act = 2'h3;
    else if (grp >= 4'h6)
      act = 2'h2;
    else if (grp >= 4'h3)
      act = 2'h1;
    else
      act = 2'h0;
    phase = grp[1:0] - {act[0], 1'b0} - act; // grp - 3*act in two bits
    // source picked by mode flag
    if (comp_mode)
      pos = cmd_reg[8 * (3 - act) +: 8];
    else
      pos = manual_pos[8 * act +: 8];
    allow = (pos <= position_limit_bits) & (comp_mode | update_select[act]);
    if (grp >= `SRL_CMD_GROUPS)
      group_byte = 8'h00;
    else if (phase == 2'h0)
      group_byte = {4'h0, pos[3:0]};
    else if (phase == 2'h1)
      group_byte = {4'h0, pos[7:4]};
    else
      group_byte = {3'h0, 1'b1, allow, 1'b0, act};
  end

  // formatter: one group per empty holding buffer
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fmt_run <= 1'b0;
      load_pend <= 1'b0;
      grp <= 4'h0;
      tx_load <= 1'b0;
      tx_data <= 8'h00;
    end
    else if (ce)
    begin
      tx_load <= 1'b0;
      // wait for the uart to take the byte before looking for empty again
      if (!tx_holding_empty)
        load_pend <= 1'b0;
      if (mode_change_pulse)
      begin
        fmt_run <= 1'b0;
        grp <= 4'h0;
      end
      else if (!fmt_run)
      begin
        grp <= 4'h0;
        fmt_run <= comp_mode ? cmd_valid : update_press;
      end
      else if (tx_holding_empty && !load_pend && !tx_load)
      begin
        // parity and framing are added by the uart itself
        tx_load <= 1'b1;
        tx_data <= group_byte;
        load_pend <= 1'b1;
        if (grp == `SRL_GRP_LAST)
        begin
          grp <= 4'h0;
          fmt_run <= comp_mode;
        end
        else
          grp <= grp + 4'h1;
      end
    end
  end

  // downlink decoder: nibbles shift in, sync byte latches the lot
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dn_shift <= 48'h0000_0000_0000;
      dn_pos <= 32'h0000_0000;
      dn_lim <= 8'h00;
      dn_temp <= 8'h00;
      dn_stat <= 4'h0;
      temperature_alert_n <= 1'b1;
      lock_alert_n <= 1'b1;
    end
    else if (ce && rx_valid)
    begin
      if (rx_data[4])
      begin
        // groups 0..B precede the sync group C
        // each pair arrives low nibble first, so the nibbles swap within every byte
        dn_pos <= {dn_shift[43:40], dn_shift[47:44], dn_shift[35:32], dn_shift[39:36],
                   dn_shift[27:24], dn_shift[31:28], dn_shift[19:16], dn_shift[23:20]};
        dn_temp <= {dn_shift[11:8], dn_shift[15:12]};
        dn_lim <= {dn_shift[3:0], dn_shift[7:4]};
        dn_stat <= rx_data[3:0];
        temperature_alert_n <= ~(rx_data[1] | rx_data[0]);
        lock_alert_n <= ~(rx_data[3] | rx_data[2]);
      end
      else
        dn_shift <= {dn_shift[43:0], rx_data[3:0]};
    end
  end

  // display source; doubled inside the converter port map
  always @*
  begin
    case (display_select)
      4'h0: disp_val = dn_temp;
      4'h1: disp_val = dn_pos[31:24];
      4'h2: disp_val = dn_pos[23:16];
      4'h3: disp_val = dn_pos[15:8];
      4'h4: disp_val = dn_pos[7:0];
      4'h5: disp_val = cmd_reg[31:24];
      4'h6: disp_val = cmd_reg[23:16];
      4'h7: disp_val = cmd_reg[15:8];
      4'h8: disp_val = cmd_reg[7:0];
      4'h9: disp_val = dn_lim;
      default: disp_val = 8'h00;
    endcase
  end
endmodule

// >>> srl_link_sequencer_properties.sv
// checker: port-level properties of the link sequencer
`timescale 1ns/1ps
module srl_checker (
  input logic clk,
  input logic nrst,
  input logic ce,
  input logic cmd_shift_clock,
  input logic host_shift_clock,
  input logic cmd_fetch_done,
  input logic status_shift_clock,
  input logic status_word_valid,
  input logic status_seq_restart,
  input logic tx_holding_empty,
  input logic tx_load,
  input logic rx_valid,
  input logic [4:0] rx_data,
  input logic temperature_alert_n,
  input logic lock_alert_n
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  logic [5:0] run_cmd; // length of the current command shift burst
  logic [5:0] run_host; // length of the current host shift burst
  logic seen_low; // buffer went busy since the last byte load
  // burst and buffer trackers; a gap clears a burst count
  always_ff @(posedge clk or negedge nrst)
    if (!nrst)
    begin
      run_cmd <= 6'h00;
      run_host <= 6'h00;
      seen_low <= 1'b1;
    end
    else
    begin
      run_cmd <= cmd_shift_clock ? run_cmd + 6'h01 : 6'h00;
      run_host <= host_shift_clock ? run_host + 6'h01 : 6'h00;
      seen_low <= tx_load ? 1'b0 : (seen_low | !tx_holding_empty);
    end
  a_status_walk: assert property (status_seq_restart |=> !status_word_valid ##1
    status_shift_clock[*8] ##1 status_shift_clock[*3] ##1 !status_shift_clock) else $error("status walk wrong");
  a_valid_low_shift: assert property (status_shift_clock |-> !status_word_valid)
    else $error("status valid during shift");
  a_valid_returns: assert property ($fell(status_shift_clock) && !status_seq_restart |=> status_word_valid)
    else $error("status valid not restored");
  a_fetch_count: assert property (cmd_fetch_done |-> cmd_shift_clock && !host_shift_clock &&
    run_cmd == 6'd31 && run_host == 6'd31) else $error("fetch pulse counts wrong");
  a_host_in_cmd: assert property (host_shift_clock |-> cmd_shift_clock) else $error("stray host shift");
  a_done_once: assert property (cmd_fetch_done |=> !cmd_fetch_done && !cmd_shift_clock)
    else $error("fetch done not single");
  a_tx_on_empty: assert property (tx_load |-> $past(tx_holding_empty) && seen_low)
    else $error("byte loaded into busy buffer");
  a_sync_alerts: assert property (ce && rx_valid && rx_data[4] |=>
    temperature_alert_n == ~|$past(rx_data[1:0]) && lock_alert_n == ~|$past(rx_data[3:2]))
    else $error("alerts not latched from sync byte");
  a_alert_hold: assert property (!(rx_valid && rx_data[4]) |=> $stable(temperature_alert_n) &&
    $stable(lock_alert_n)) else $error("alerts moved without sync");
  c_fetch: cover property (cmd_fetch_done);
  c_uplink: cover property (tx_load ##[1:20] tx_load);
  c_status: cover property (status_seq_restart ##2 status_shift_clock);
endmodule
bind srl_link_sequencer srl_checker chk (.clk, .nrst, .ce, .cmd_shift_clock, .host_shift_clock, .cmd_fetch_done,
  .status_shift_clock, .status_word_valid, .status_seq_restart, .tx_holding_empty, .tx_load, .rx_valid,
  .rx_data, .temperature_alert_n, .lock_alert_n);

// >>> srl_map.vh
// constants and register map for the subreflector link sequencer
`ifndef SRL_MAP_VH
`define SRL_MAP_VH
// register byte offsets
`define SRL_OFS_CTRL 8'h00
`define SRL_OFS_LIMIT 8'h04
`define SRL_OFS_MANPOS 8'h08
`define SRL_OFS_STATUS 8'h0c
`define SRL_OFS_CMD 8'h10
`define SRL_OFS_DNPOS 8'h14
`define SRL_OFS_DNMISC 8'h18
`define SRL_OFS_DISP 8'h1c
// control register fields
`define SRL_CTRL_COMP 0
`define SRL_CTRL_PRESS 1
`define SRL_CTRL_USEL_LO 4
`define SRL_CTRL_DSEL_LO 8
// reset values
`define SRL_CTRL_RST 32'h0000_0000
`define SRL_LIMIT_RST 12'h000
`define SRL_MANPOS_RST 32'h0000_0000
// timing
`define SRL_CLK_KHZ 125000
`define SRL_POR_MS 2000
`define SRL_LOAD_DLY_MS 500
// sequence lengths
`define SRL_FETCH_LAST 5'h1f
`define SRL_STAT_LAST 4'ha
`define SRL_GRP_LAST 4'he
`define SRL_CMD_GROUPS 4'hc
`endif

// >>> tb_srl_link_sequencer.sv
// self-checking bench for the link sequencer
`timescale 1ns/1ps
module tb_srl_link_sequencer;
  logic clk = 0, nrst = 0, ce = 1, cyc = 0, stb = 0, we = 0, loaded = 0, hload = 0, rxv = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0, busy = 4'h1;
  logic [31:0] wdat = 32'h0, rd, hword = 32'h0;
  logic [4:0] rxd = 5'h00;
  logic [10:0] sword; // serial status word as shifted out
  logic [7:0] tx_q[$]; // uplink bytes in load order
  wire ack, cmd_sc, host_sc, done, sdat, ssc, svalid, srst, txl, temperature_alert_n_n, lock_alert_n_n, tx_emp, hdat;
  wire [31:0] rdat;
  wire [7:0] txd;
  int n_mismatch = 0, comparisons = 0, n_cmd = 0, n_host = 0, n_srst = 0, base;
  srl_link_sequencer #(.POR_CYCLES(20), .LOAD_DLY_CYCLES(10)) uut (
    .clk(clk), .nrst(nrst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_ack_o(ack), .wb_dat_o(rdat),
    .host_cmd_loaded(loaded), .host_data_in(hdat), .cmd_shift_clock(cmd_sc),
    .host_shift_clock(host_sc), .cmd_fetch_done(done), .status_data(sdat),
    .status_shift_clock(ssc), .status_word_valid(svalid), .status_seq_restart(srst),
    .tx_holding_empty(tx_emp), .tx_load(txl), .tx_data(txd), .rx_valid(rxv), .rx_data(rxd),
    .temperature_alert_n(temperature_alert_n_n), .lock_alert_n(lock_alert_n_n));
  srl_far_end far (.clk(clk), .nrst(nrst), .host_word(hword), .host_load(hload),
    .host_shift_clock(host_sc), .host_data_in(hdat), .tx_busy(busy), .tx_load(txl),
    .tx_holding_empty(tx_emp));
  initial
  begin
    forever #4 clk = ~clk;
  end
  // record status bits, shift pulses, restarts and uplink bytes
  always @(posedge clk)
  begin
    if (ssc)
      sword <= {sword[9:0], sdat};
    if (cmd_sc)
      n_cmd++;
    if (host_sc)
      n_host++;
    if (srst)
      n_srst++;
    if (txl)
      tx_q.push_back(txd);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  // one classic bus cycle; request held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    rd = rdat;
    chk({31'h0, ack}, 32'h1, "bus answer");
    cyc <= 0;
    stb <= 0;
  endtask
  // wait for a restart after count b, then for the full word
  task automatic stat(input int b, input logic [10:0] exp);
    for (int i = 0; i < 200 && n_srst <= b; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    for (int i = 0; i < 40 && svalid !== 1'b1; i++) @(posedge clk);
    chk({31'h0, svalid}, 32'h1, "status valid after word");
    chk({21'h0, sword}, {21'h0, exp}, "status word");
  endtask
  task automatic dn(input logic [4:0] v); // one downlink byte strobe
    @(posedge clk);
    rxv <= 1;
    rxd <= v;
    @(posedge clk);
    rxv <= 0;
    rxd <= ~v;
    @(posedge clk);
  endtask
  // expected uplink group g; pos holds actuator 1 in the low byte
  function automatic logic [7:0] grp(input int g, input logic [31:0] pos, input logic [3:0] m);
    logic [7:0] p;
    if (g > 11)
      return 8'h00;
    p = pos[8 * (g / 3) +: 8];
    if (g % 3 == 0)
      return {4'h0, p[3:0]};
    if (g % 3 == 1)
      return {4'h0, p[7:4]};
    return {4'h1, p <= 8'h80 && m[g / 3], 1'b0, 2'(g / 3)};
  endfunction
  task automatic up(input logic [31:0] pos, input logic [3:0] m);
    for (int g = 0; g < 15; g++)
      chk({24'h0, tx_q[g]}, {24'h0, grp(g, pos, m)}, "uplink byte");
  endtask
  task automatic end_test(input string name);
    $display("test %s done, mismatches so far %0d", name, n_mismatch);
  endtask
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // cut a hang short: the tests need well under 5000 cycles
  initial
  begin
    #80000;
    n_mismatch++;
    finish_test;
  end
  initial
  begin
    repeat (16) @(posedge clk);
    chk({30'h0, temperature_alert_n_n, lock_alert_n_n}, 32'h3, "alerts in reset");
    nrst <= 1;
    stat(0, 11'h300);
    end_test("power-up");
    wb(1, 8'h04, 32'h0000_0999);
    wb(0, 8'h04, 32'h0);
    chk(rd, 32'h000f_f999, "limit saturates");
    wb(1, 8'h04, 32'h0000_0128);
    wb(0, 8'h04, 32'h0);
    chk(rd, 32'h0008_0128, "limit conversion");
    wb(1, 8'h10, 32'hffff_ffff);
    wb(0, 8'h10, 32'h0);
    chk(rd, 32'h0, "read-only command word");
    wb(0, 8'h20, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    end_test("registers");
    for (int g = 0; g < 12; g++)
      dn({1'b0, 4'(g + 1)});
    dn(5'h11);
    wb(0, 8'h14, 32'h0);
    chk(rd, 32'h2143_6587, "downlink positions");
    wb(0, 8'h18, 32'h0);
    chk(rd, 32'h0001_a9cb, "downlink limit and temperature");
    chk({30'h0, temperature_alert_n_n, lock_alert_n_n}, 32'h1, "temperature alert");
    wb(1, 8'h00, 32'h0000_0100);
    wb(0, 8'h1c, 32'h0);
    chk(rd, 32'h0000_0066, "display doubled");
    dn(5'h14);
    chk({30'h0, temperature_alert_n_n, lock_alert_n_n}, 32'h2, "lock alert");
    ce <= 0;
    dn(5'h10);
    chk({30'h0, temperature_alert_n_n, lock_alert_n_n}, 32'h2, "frozen while disabled");
    ce <= 1;
    end_test("downlink");
    base = n_srst;
    wb(1, 8'h00, 32'h0000_0001);
    stat(base, 11'h680);
    end_test("mode change");
    hword <= 32'h1122_8094;
    hload <= 1;
    busy <= 4'h6;
    @(posedge clk);
    hload <= 0;
    loaded <= 1;
    n_cmd = 0;
    n_host = 0;
    base = n_srst;
    @(posedge clk);
    loaded <= 0;
    repeat (5) @(posedge clk);
    chk(n_srst, base, "restart not early");
    for (int i = 0; i < 100 && done !== 1'b1; i++) @(posedge clk);
    chk({31'h0, done}, 32'h1, "fetch done");
    repeat (3) @(posedge clk);
    chk(n_cmd, 32, "local shift count");
    chk(n_host, 31, "host shift count");
    chk(n_srst, base + 1, "delayed restart");
    wb(0, 8'h10, 32'h0);
    chk(rd, 32'h1122_8094, "fetched word");
    for (int i = 0; i < 1000 && tx_q.size() < 20; i++) @(posedge clk);
    up(32'h9480_2211, 4'hf);
    chk({24'h0, tx_q[15]}, 32'h1, "groups repeat");
    end_test("computer fetch");
    busy <= 4'h1;
    wb(1, 8'h00, 32'h0);
    wb(1, 8'h08, 32'h8105_807f);
    loaded <= 1;
    n_cmd = 0;
    @(posedge clk);
    loaded <= 0;
    repeat (50) @(posedge clk);
    chk(n_cmd, 0, "load ignored in manual");
    tx_q.delete();
    wb(1, 8'h00, 32'h0000_00b2);
    for (int i = 0; i < 300 && tx_q.size() < 15; i++) @(posedge clk);
    repeat (100) @(posedge clk);
    chk(tx_q.size(), 15, "one pass per press");
    up(32'h8105_807f, 4'hb);
    end_test("manual");
    finish_test;
  end
endmodule
